/* src/mcs_module_control.sv */
// Sideband pins, serial slave and per-channel status and control bytes
`timescale 1ns/1ps
module mcs_module_control #(
    parameter int unsigned INIT_CYCLES    = mcs_pkg::INIT_CYCLES_DEF,
    parameter bit          POWER_CLASS_1  = 1'b1
) (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       MODULE_SELECT_N,
    input  wire logic       MODULE_RESET_N,
    input  wire logic       LOW_POWER_REQUEST,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    output logic            INTERRUPT_N_OUT,
    output logic            INTERRUPT_N_OE_N,
    output logic            MODULE_PRESENT_N,
    input  wire logic [3:0] RX_LOS_RAW,
    input  wire logic [3:0] TX_LOS_RAW,
    input  wire logic [3:0] TX_FAULT_RAW,
    output logic [3:0]      TX_ENABLE,
    output logic [3:0]      RX_OUTPUT_ENABLE,
    output logic [3:0]      TX_SQUELCH_ENABLE,
    output logic [3:0]      RX_SQUELCH_ENABLE,
    output logic            LOW_POWER_MODE
);
    import mcs_pkg::*;

    typedef struct packed {
        logic                  sel_s1;
        logic                  sel_s2;
        logic                  rst_s1;
        logic                  rst_s2;
        logic                  lp_s1;
        logic                  lp_s2;
        logic                  scl_s1;
        logic                  scl_s2;
        logic                  scl_p;
        logic                  sda_s1;
        logic                  sda_s2;
        logic                  sda_p;
        logic [11:0]           raw_s1;
        logic [11:0]           raw_s2;
        logic [RST_CNT_W-1:0]  rst_cnt;
        logic                  rst_armed;
        logic [INIT_CNT_W-1:0] init_cnt;
        logic                  not_ready;
        logic                  done_flag;
        logic [7:0]            los_flags;
        logic [3:0]            flt_flags;
        logic [3:0]            flt_state;
        logic [3:0]            txdis;
        logic [7:0]            sqdis;
        logic [3:0]            rxdis;
        logic [7:0]            los_mask;
        logic [3:0]            flt_mask;
        logic [7:0]            page;
        mcs_serial_t           st;
        logic [3:0]            cnt;
        logic [7:0]            shreg;
        logic [7:0]            ptr;
        logic                  rw;
        logic                  ptr_phase;
        logic                  sda_oe_n;
        logic                  int_oe_n;
        logic [3:0]            tx_en;
        logic [3:0]            rx_en;
        logic [3:0]            txsq_en;
        logic [3:0]            rxsq_en;
        logic                  lpm;
    } mcs_state_t;

    mcs_state_t q_q;
    mcs_state_t q_d;

    // Control bytes on the upper page exist only while page 3 is selected
    function automatic logic on_ctrl_page(input logic [7:0] addr, input logic [7:0] pg);
        on_ctrl_page = addr[7] && (pg == PAGE_CONTROL);
    endfunction

    always_comb begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_c;
        logic       stop_c;
        logic       selected;
        logic       load;
        logic       wr_en;
        logic       soft_rst;
        logic       clr_los;
        logic       clr_flt;
        logic       clr_done;
        logic [3:0] toggle;
        logic [7:0] rdata;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c  = 1'b0;
        stop_c   = 1'b0;
        selected = 1'b0;
        load     = 1'b0;
        wr_en    = 1'b0;
        soft_rst = 1'b0;
        clr_los  = 1'b0;
        clr_flt  = 1'b0;
        clr_done = 1'b0;
        toggle   = 4'h0;
        rdata    = 8'h00;
        q_d = q_q;

        q_d.sel_s1 = MODULE_SELECT_N;
        q_d.sel_s2 = q_q.sel_s1;
        q_d.rst_s1 = MODULE_RESET_N;
        q_d.rst_s2 = q_q.rst_s1;
        q_d.lp_s1  = LOW_POWER_REQUEST;
        q_d.lp_s2  = q_q.lp_s1;
        q_d.scl_s1 = SCL_IN;
        q_d.scl_s2 = q_q.scl_s1;
        q_d.scl_p  = q_q.scl_s2;
        q_d.sda_s1 = SDA_IN;
        q_d.sda_s2 = q_q.sda_s1;
        q_d.sda_p  = q_q.sda_s2;
        q_d.raw_s1 = {TX_FAULT_RAW, TX_LOS_RAW, RX_LOS_RAW};
        q_d.raw_s2 = q_q.raw_s1;

        scl_rise = q_q.scl_s2 && !q_q.scl_p;
        scl_fall = !q_q.scl_s2 && q_q.scl_p;
        start_c  = q_q.scl_s2 && q_q.scl_p && q_q.sda_p && !q_q.sda_s2;
        stop_c   = q_q.scl_s2 && q_q.scl_p && !q_q.sda_p && q_q.sda_s2;
        selected = !q_q.sel_s2;

        // RULE16: interrupt mirror readable
        unique case (q_q.ptr)
            ADDR_INT_STATUS: begin
                rdata[NOT_READY_BIT]  = q_q.not_ready;
                rdata[INT_MIRROR_BIT] = !q_q.int_oe_n;
            end
            // RULE18: rx loss readback
            // RULE19: tx loss readback
            ADDR_LOS_FLAGS:   rdata = q_q.los_flags;
            // RULE20: fault readback
            ADDR_FAULT_FLAGS: rdata = {4'h0, q_q.flt_flags};
            ADDR_TX_DISABLE:  rdata = {4'h0, q_q.txdis};
            ADDR_LOS_MASK:    rdata = q_q.los_mask;
            ADDR_FAULT_MASK:  rdata = {4'h0, q_q.flt_mask};
            ADDR_PAGE_SELECT: rdata = q_q.page;
            ADDR_SQ_DISABLE:  rdata = on_ctrl_page(q_q.ptr, q_q.page) ? q_q.sqdis : 8'h00;
            ADDR_RX_DISABLE:  rdata = on_ctrl_page(q_q.ptr, q_q.page) ? {q_q.rxdis, 4'h0} : 8'h00;
            default:          rdata = 8'h00;
        endcase

        unique case (q_q.st)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    q_d.shreg = {q_q.shreg[6:0], q_q.sda_s2};
                    q_d.cnt   = q_q.cnt + 4'h1;
                end else if (scl_fall && q_q.cnt == 4'h8) begin
                    q_d.cnt = 4'h0;
                    if (q_q.shreg[7:1] == DEVICE_ADDR) begin
                        q_d.sda_oe_n = 1'b0;
                        q_d.rw       = q_q.shreg[0];
                        q_d.st       = ST_ADDR_ACK;
                    end else begin
                        q_d.st = ST_IDLE;
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    if (q_q.rw) begin
                        load = 1'b1;
                    end else begin
                        q_d.sda_oe_n  = 1'b1;
                        q_d.ptr_phase = 1'b1;
                        q_d.st        = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (scl_rise) begin
                    q_d.shreg = {q_q.shreg[6:0], q_q.sda_s2};
                    q_d.cnt   = q_q.cnt + 4'h1;
                end else if (scl_fall && q_q.cnt == 4'h8) begin
                    q_d.cnt      = 4'h0;
                    q_d.sda_oe_n = 1'b0;
                    q_d.st       = ST_WRITE_ACK;
                    if (q_q.ptr_phase) begin
                        q_d.ptr       = q_q.shreg;
                        q_d.ptr_phase = 1'b0;
                    end else begin
                        wr_en     = 1'b1;
                        q_d.ptr   = q_q.ptr + 8'h01;
                    end
                end
            end
            ST_WRITE_ACK: begin
                if (scl_fall) begin
                    q_d.sda_oe_n = 1'b1;
                    q_d.st       = ST_WRITE;
                end
            end
            ST_READ: begin
                if (scl_fall) begin
                    if (q_q.cnt == 4'h8) begin
                        q_d.sda_oe_n = 1'b1;
                        q_d.cnt      = 4'h0;
                        q_d.st       = ST_READ_ACK;
                    end else begin
                        q_d.sda_oe_n = q_q.shreg[7];
                        q_d.shreg    = {q_q.shreg[6:0], 1'b0};
                        q_d.cnt      = q_q.cnt + 4'h1;
                    end
                end
            end
            ST_READ_ACK: begin
                // A not-acknowledge ends the read; the host then sends stop
                if (scl_rise && q_q.sda_s2) begin
                    q_d.st = ST_IDLE;
                end else if (scl_fall) begin
                    load = 1'b1;
                end
            end
        endcase

        if (load) begin
            q_d.sda_oe_n = rdata[7];
            q_d.shreg    = {rdata[6:0], 1'b0};
            q_d.cnt      = 4'h1;
            q_d.ptr      = q_q.ptr + 8'h01;
            q_d.st       = ST_READ;
            clr_done     = (q_q.ptr == ADDR_INT_STATUS);
            clr_los      = (q_q.ptr == ADDR_LOS_FLAGS);
            clr_flt      = (q_q.ptr == ADDR_FAULT_FLAGS);
        end

        // RULE1: deselect silences slave
        if (!selected || stop_c) begin
            q_d.st       = ST_IDLE;
            q_d.sda_oe_n = 1'b1;
        end else if (start_c) begin
            q_d.st       = ST_ADDR;
            q_d.cnt      = 4'h0;
            q_d.sda_oe_n = 1'b1;
        end

        if (wr_en) begin
            unique case (q_q.ptr)
                // RULE23: tx disable byte
                ADDR_TX_DISABLE: begin
                    q_d.txdis = q_q.shreg[3:0];
                    toggle    = q_q.shreg[3:0] ^ q_q.txdis;
                end
                ADDR_LOS_MASK:    q_d.los_mask = q_q.shreg;
                ADDR_FAULT_MASK:  q_d.flt_mask = q_q.shreg[3:0];
                ADDR_PAGE_SELECT: q_d.page     = q_q.shreg;
                // RULE25: tx squelch disable
                // RULE26: rx squelch disable
                ADDR_SQ_DISABLE: begin
                    if (on_ctrl_page(q_q.ptr, q_q.page)) begin
                        q_d.sqdis = q_q.shreg;
                    end
                end
                // RULE24: rx output disable
                ADDR_RX_DISABLE: begin
                    if (on_ctrl_page(q_q.ptr, q_q.page)) begin
                        q_d.rxdis = q_q.shreg[7:4];
                    end
                end
                default: begin
                end
            endcase
        end

        // RULE28: latch until read
        q_d.los_flags = q_q.raw_s2[7:0] | (q_q.los_flags & {8{!clr_los}});
        q_d.flt_flags = q_q.raw_s2[11:8] | (q_q.flt_flags & {4{!clr_flt}});
        // RULE22: toggle clears fault
        q_d.flt_state = q_q.raw_s2[11:8] | (q_q.flt_state & ~toggle);

        // RULE6: count low reset time
        if (!q_q.rst_s2) begin
            if (q_q.rst_cnt != RST_CNT_W'(RESET_MIN_CYCLES)) begin
                q_d.rst_cnt = q_q.rst_cnt + 1'b1;
            end else begin
                q_d.rst_armed = 1'b1;
            end
        end else begin
            // RULE7: init starts on rise
            soft_rst      = q_q.rst_armed;
            q_d.rst_cnt   = '0;
            q_d.rst_armed = 1'b0;
        end

        // RULE8: ready after init time
        if (q_q.not_ready) begin
            if (q_q.init_cnt == INIT_CNT_W'(INIT_CYCLES - 1)) begin
                q_d.not_ready = 1'b0;
                // RULE10: completion interrupt posted
                q_d.done_flag = 1'b1;
            end else begin
                q_d.init_cnt = q_q.init_cnt + 1'b1;
            end
        end else if (clr_done) begin
            q_d.done_flag = 1'b0;
        end

        // RULE5: module reset to defaults
        // RULE17: volatile soft controls
        if (soft_rst) begin
            q_d.txdis     = 4'h0;
            q_d.sqdis     = 8'h00;
            q_d.rxdis     = 4'h0;
            q_d.los_mask  = 8'h00;
            q_d.flt_mask  = 4'h0;
            q_d.page      = 8'h00;
            q_d.los_flags = 8'h00;
            q_d.flt_flags = 4'h0;
            q_d.flt_state = q_q.raw_s2[11:8];
            q_d.done_flag = 1'b0;
            q_d.not_ready = 1'b1;
            q_d.init_cnt  = '0;
        end

        // RULE27: unmasked flags drive interrupt
        // RULE14: open-collector drive low
        q_d.int_oe_n = !(q_q.done_flag || |(q_q.los_flags & ~q_q.los_mask)
                         || |(q_q.flt_flags & ~q_q.flt_mask));
        // RULE21: fault kills transmitter
        q_d.tx_en   = ~(q_q.txdis | q_q.flt_state) & {4{!q_q.not_ready}};
        q_d.rx_en   = ~q_q.rxdis & {4{!q_q.not_ready}};
        q_d.txsq_en = ~q_q.sqdis[3:0];
        q_d.rxsq_en = ~q_q.sqdis[7:4];
        // RULE12: class 1 ignores request
        q_d.lpm     = q_q.lp_s2 && !POWER_CLASS_1;

        // RULE11: power-up posts completion
        if (!RESET_N) begin
            q_d           = '0;
            q_d.not_ready = 1'b1;
            q_d.sda_oe_n  = 1'b1;
            q_d.int_oe_n  = 1'b1;
            // RULE2: select idles deselected
            q_d.sel_s1    = 1'b1;
            q_d.sel_s2    = 1'b1;
            q_d.rst_s1    = 1'b1;
            q_d.rst_s2    = 1'b1;
            q_d.txsq_en   = 4'hf;
            q_d.rxsq_en   = 4'hf;
        end
    end

    always_ff @(posedge CLK) begin
        q_q <= q_d;
    end

    assign SDA_OUT           = 1'b0;
    assign SDA_OE_N          = q_q.sda_oe_n;
    assign INTERRUPT_N_OUT   = 1'b0;
    assign INTERRUPT_N_OE_N  = q_q.int_oe_n;
    // RULE13: presence tied to ground
    assign MODULE_PRESENT_N  = 1'b0;
    assign TX_ENABLE         = q_q.tx_en;
    assign RX_OUTPUT_ENABLE  = q_q.rx_en;
    assign TX_SQUELCH_ENABLE = q_q.txsq_en;
    assign RX_SQUELCH_ENABLE = q_q.rxsq_en;
    assign LOW_POWER_MODE    = q_q.lpm;
endmodule

/* src/mcs_pkg.sv */
// Constants and types for the module control and status block
// Operation
// RULE1: Serial slave answers only while select low
// RULE2: Select input idles high when undriven
// RULE3: Host waits deassert time after deselect
// RULE4: Host waits assert time after select
// RULE5: Long reset pulse restores all default settings
// RULE6: Reset low over 2 us is valid
// RULE7: Init timing starts at reset rising edge
// RULE8: Functional within 2000 ms after reset
// RULE9: Host ignores status bits during reset
// RULE10: Completion shown by interrupt, not-ready negated
// RULE11: Power-up posts completion interrupt unprompted
// RULE12: Low-power input honored except power class 1
// RULE13: Presence output tied low in module
// RULE14: Interrupt open-collector, low flags fault
// RULE15: Host reads status to find source
// RULE16: Interrupt mirrored at byte 2 bit 1
// RULE17: Soft controls per channel and volatile
// RULE18: Rx loss flags byte 3 bits 0-3
// RULE19: Tx loss flags byte 3 bits 4-7
// RULE20: Tx fault flags byte 4 bits 0-3
// RULE21: Tx fault disables that channel transmitter
// RULE22: Reset or disable toggle clears fault state
// RULE23: Tx disable controls byte 86 bits 0-3
// RULE24: Rx output disable page 3 byte 241
// RULE25: Tx squelch disable page 3 byte 240 low
// RULE26: Rx squelch disable page 3 byte 240 high
// RULE27: Unmasked latched flag drives interrupt low
// RULE28: Flag stays until read, re-sets if present
package mcs_pkg;
    localparam logic [7:0]  ADDR_INT_STATUS  = 8'h02;
    localparam logic [7:0]  ADDR_LOS_FLAGS   = 8'h03;
    localparam logic [7:0]  ADDR_FAULT_FLAGS = 8'h04;
    localparam logic [7:0]  ADDR_TX_DISABLE  = 8'h56;
    localparam logic [7:0]  ADDR_LOS_MASK    = 8'h64;
    localparam logic [7:0]  ADDR_FAULT_MASK  = 8'h65;
    localparam logic [7:0]  ADDR_PAGE_SELECT = 8'h7f;
    localparam logic [7:0]  ADDR_SQ_DISABLE  = 8'hf0;
    localparam logic [7:0]  ADDR_RX_DISABLE  = 8'hf1;
    localparam logic [7:0]  PAGE_CONTROL     = 8'h03;
    localparam logic [6:0]  DEVICE_ADDR      = 7'h50;
    localparam int unsigned NOT_READY_BIT    = 0;
    localparam int unsigned INT_MIRROR_BIT   = 1;
    localparam int unsigned CLK_KHZ          = 20000;
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned T_RESET_INIT_NS  = 2000;
    localparam int unsigned T_INIT_MS        = 2000;
    localparam int unsigned RESET_MIN_CYCLES =
        (T_RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_CYCLES_DEF  = T_INIT_MS * CLK_KHZ;
    localparam int unsigned INIT_CNT_W       = 26;
    localparam int unsigned RST_CNT_W        = 6;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
    } mcs_serial_t;
endpackage

/* verification/mcs_assertions.sv */
// Port assertions for the module control block
`timescale 1ns/1ps
module mcs_assertions #(
    parameter int unsigned INIT_CYCLES   = 20,
    parameter bit          POWER_CLASS_1 = 1'b1
) (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       MODULE_SELECT_N,
    input wire logic       MODULE_RESET_N,
    input wire logic       LOW_POWER_REQUEST,
    input wire logic [3:0] TX_FAULT_RAW,
    input wire logic       SDA_OE_N,
    input wire logic       INTERRUPT_N_OUT,
    input wire logic       INTERRUPT_N_OE_N,
    input wire logic       MODULE_PRESENT_N,
    input wire logic [3:0] TX_ENABLE,
    input wire logic [3:0] RX_OUTPUT_ENABLE,
    input wire logic [3:0] TX_SQUELCH_ENABLE,
    input wire logic [3:0] RX_SQUELCH_ENABLE,
    input wire logic       LOW_POWER_MODE
);
    import mcs_pkg::*;
    localparam int INIT_LO = INIT_CYCLES - 2;
    localparam int INIT_HI = INIT_CYCLES + 8;
    logic [31:0] up_cnt_q;
    logic        seen_q;
    logic [7:0]  low_cnt_q;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    // Power-up timer stops at the first completion interrupt
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            up_cnt_q <= 32'h0;
            seen_q   <= 1'b0;
        end else if (!seen_q) begin
            up_cnt_q <= up_cnt_q + 32'h1;
            seen_q   <= !INTERRUPT_N_OE_N;
        end
        if (MODULE_RESET_N)
            low_cnt_q <= 8'h0;
        else if (low_cnt_q != 8'hff)
            low_cnt_q <= low_cnt_q + 8'h1;
    end
    sequence long_pulse_s;
        MODULE_RESET_N && low_cnt_q > 8'h2d;
    endsequence
    sequence short_pulse_s;
        MODULE_RESET_N && low_cnt_q != 8'h0 && low_cnt_q < 8'h1e;
    endsequence
    reset_dflt_a: assert property (disable iff (1'b0) !RESET_N |=>
        (SDA_OE_N && INTERRUPT_N_OE_N && TX_ENABLE == 4'h0 && RX_OUTPUT_ENABLE == 4'h0
        && TX_SQUELCH_ENABLE == 4'hf && RX_SQUELCH_ENABLE == 4'hf && !LOW_POWER_MODE))
        else $error("outputs not at reset values");
    presence_tie_a: assert property (MODULE_PRESENT_N == 1'b0)
        else $error("presence output not low");
    int_open_a: assert property (INTERRUPT_N_OUT == 1'b0)
        else $error("interrupt drives high");
    deselect_quiet_a: assert property (MODULE_SELECT_N [*6] |-> SDA_OE_N)
        else $error("data line pulled while deselected");
    fault_txoff_a: assert property ($stable(TX_FAULT_RAW) [*5] |->
        (TX_FAULT_RAW & TX_ENABLE) == 4'h0)
        else $error("transmitter on during fault");
    low_power_a: assert property ((!LOW_POWER_REQUEST || POWER_CLASS_1) [*5]
        |-> !LOW_POWER_MODE)
        else $error("low power without request");
    init_late_a: assert property (!(!seen_q && up_cnt_q > INIT_HI))
        else $error("completion interrupt late");
    init_early_a: assert property (!seen_q && up_cnt_q < INIT_LO |->
        INTERRUPT_N_OE_N)
        else $error("completion interrupt early");
    mod_reset_a: assert property (long_pulse_s |-> ##[2:8]
        (TX_ENABLE == 4'h0 && TX_SQUELCH_ENABLE == 4'hf && RX_SQUELCH_ENABLE == 4'hf))
        else $error("module reset did not restore defaults");
    short_pulse_a: assert property (short_pulse_s |->
        $stable(TX_SQUELCH_ENABLE) [*8])
        else $error("short reset pulse acted");
endmodule
bind mcs_module_control mcs_assertions #(.INIT_CYCLES(INIT_CYCLES),
    .POWER_CLASS_1(POWER_CLASS_1)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
    .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
    .LOW_POWER_REQUEST(LOW_POWER_REQUEST), .TX_FAULT_RAW(TX_FAULT_RAW),
    .SDA_OE_N(SDA_OE_N), .INTERRUPT_N_OUT(INTERRUPT_N_OUT),
    .INTERRUPT_N_OE_N(INTERRUPT_N_OE_N), .MODULE_PRESENT_N(MODULE_PRESENT_N),
    .TX_ENABLE(TX_ENABLE), .RX_OUTPUT_ENABLE(RX_OUTPUT_ENABLE),
    .TX_SQUELCH_ENABLE(TX_SQUELCH_ENABLE), .RX_SQUELCH_ENABLE(RX_SQUELCH_ENABLE),
    .LOW_POWER_MODE(LOW_POWER_MODE));

/* verification/mcs_host_model.sv */
// Behavioural host: sideband pins and two-wire serial master
`timescale 1ns/1ps
module mcs_host_model #(
    parameter int SEL_WAIT = 10
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull,
    output logic      module_select_n,
    output logic      module_reset_n,
    output logic      low_power_request
);
    import mcs_pkg::*;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        module_select_n = 1'b1;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
    end
    // Each clock phase is four cycles; the slave has no timeout, so slower phases also work
    task automatic half();
        repeat (2) @(negedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        half();
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        half();
    endtask
    task automatic frame_start();
        logic r;
        bit_io(1'b1, r);
        sda_pull = 1'b1;
        half();
    endtask
    task automatic frame_stop();
        logic r;
        bit_io(1'b0, r);
        sda_pull = 1'b0;
        half();
    endtask
    task automatic byte_io(input logic [7:0] b, input logic ack_in,
                           output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
        bit_io(ack_in, nak);
    endtask
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [2:0] n;
        frame_start();
        byte_io({DEVICE_ADDR, 1'b0}, 1'b1, r, n[0]);
        byte_io(ptr, 1'b1, r, n[1]);
        byte_io(d, 1'b1, r, n[2]);
        frame_stop();
        ok = (n == 3'h0);
    endtask
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [2:0] n;
        logic       x;
        frame_start();
        byte_io({DEVICE_ADDR, 1'b0}, 1'b1, r, n[0]);
        byte_io(ptr, 1'b1, r, n[1]);
        frame_start();
        byte_io({DEVICE_ADDR, 1'b1}, 1'b1, r, n[2]);
        byte_io(8'hff, 1'b1, d, x);
        frame_stop();
        ok = (n == 3'h0);
    endtask
    task automatic sel_on();
        module_select_n = 1'b0;
        repeat (SEL_WAIT) @(negedge clk);
    endtask
    task automatic sel_off();
        module_select_n = 1'b1;
        repeat (SEL_WAIT) @(negedge clk);
    endtask
    task automatic reset_pulse(input int cycles);
        module_reset_n = 1'b0;
        repeat (cycles) @(negedge clk);
        module_reset_n = 1'b1;
    endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the module control block
`timescale 1ns/1ps
module tb;
    import mcs_pkg::*;
    localparam int INIT_N = 20;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [3:0] rx_los = 4'h0;
    logic [3:0] tx_los = 4'h0;
    logic [3:0] tx_flt = 4'h0;
    logic       scl, sda_pull, sel_n, mrst_n, lp_req, sda_out, sda_oe_n;
    logic       int_out, int_oe_n, present_n, lp_mode, ok;
    logic [3:0] tx_en, rx_en, tx_sq, rx_sq;
    logic [7:0] rd_q;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n;
    // Open-drain wires with host pull-ups
    wire        sda = !(sda_pull || (!sda_oe_n && !sda_out));
    wire        int_n = int_oe_n ? 1'b1 : int_out;
    always #25 clk = ~clk;
    mcs_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull),
        .module_select_n(sel_n), .module_reset_n(mrst_n), .low_power_request(lp_req));
    mcs_module_control #(.INIT_CYCLES(INIT_N), .POWER_CLASS_1(1'b0)) DUT (
        .CLK(clk), .RESET_N(reset_n), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(mrst_n),
        .LOW_POWER_REQUEST(lp_req), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .INTERRUPT_N_OUT(int_out), .INTERRUPT_N_OE_N(int_oe_n),
        .MODULE_PRESENT_N(present_n), .RX_LOS_RAW(rx_los), .TX_LOS_RAW(tx_los),
        .TX_FAULT_RAW(tx_flt), .TX_ENABLE(tx_en), .RX_OUTPUT_ENABLE(rx_en),
        .TX_SQUELCH_ENABLE(tx_sq), .RX_SQUELCH_ENABLE(rx_sq), .LOW_POWER_MODE(lp_mode));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d, ok);
        check(8'(ok), 8'h01);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rd_q, ok);
        check(8'(ok), 8'h01);
        check(rd_q, exp);
    endtask
    task automatic wait_int(output int k);
        k = 0;
        while (int_n !== 1'b0 && k < 200) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic pulse(input logic [3:0] rx, input logic [3:0] tx, input logic [3:0] f);
        rx_los = rx;
        tx_los = tx;
        tx_flt = f;
        repeat (6) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        wait_int(n);
        check(8'(n > INIT_N - 3 && n < INIT_N + 9), 8'h01);
        check(8'(present_n), 8'h00);
        host.sel_on();
        rd(ADDR_INT_STATUS, 8'h02);
        check(8'(int_n), 8'h01);
        rd(ADDR_INT_STATUS, 8'h00);
        check({tx_en, rx_en}, 8'hff);
        check({tx_sq, rx_sq}, 8'hff);
        wr(ADDR_PAGE_SELECT, PAGE_CONTROL);
        rd(ADDR_SQ_DISABLE, 8'h00);
        wr(ADDR_SQ_DISABLE, 8'ha5);
        wr(ADDR_RX_DISABLE, 8'h30);
        wr(ADDR_TX_DISABLE, 8'h09);
        rd(ADDR_SQ_DISABLE, 8'ha5);
        rd(ADDR_TX_DISABLE, 8'h09);
        check({tx_sq, rx_sq}, 8'ha5);
        check({tx_en, rx_en}, 8'h6c);
        rd(8'h10, 8'h00);
        pulse(4'h5, 4'h8, 4'h0);
        pulse(4'h0, 4'h0, 4'h0);
        check(8'(int_n), 8'h00);
        rd(ADDR_LOS_FLAGS, 8'h85);
        rd(ADDR_LOS_FLAGS, 8'h00);
        check(8'(int_n), 8'h01);
        pulse(4'h2, 4'h0, 4'h0);
        rd(ADDR_LOS_FLAGS, 8'h02);
        pulse(4'h0, 4'h0, 4'h0);
        rd(ADDR_LOS_FLAGS, 8'h02);
        rd(ADDR_LOS_FLAGS, 8'h00);
        wr(ADDR_LOS_MASK, 8'hff);
        pulse(4'h1, 4'h0, 4'h0);
        check(8'(int_n), 8'h01);
        pulse(4'h0, 4'h0, 4'h6);
        pulse(4'h0, 4'h0, 4'h2);
        check(8'(tx_en), 8'h00);
        rd(ADDR_FAULT_FLAGS, 8'h06);
        wr(ADDR_TX_DISABLE, 8'h0f);
        wr(ADDR_TX_DISABLE, 8'h09);
        check(8'(tx_en), 8'h04);
        pulse(4'h0, 4'h0, 4'h0);
        rd(ADDR_FAULT_FLAGS, 8'h02);
        host.low_power_request = 1'b1;
        repeat (6) @(negedge clk);
        check(8'(lp_mode), 8'h01);
        host.low_power_request = 1'b0;
        repeat (6) @(negedge clk);
        check(8'(lp_mode), 8'h00);
        host.sel_off();
        host.write_reg(ADDR_TX_DISABLE, 8'h00, ok);
        check(8'(ok), 8'h00);
        check(8'(tx_en), 8'h04);
        host.sel_on();
        host.reset_pulse(10);
        repeat (10) @(negedge clk);
        check({tx_sq, rx_sq}, 8'ha5);
        host.reset_pulse(60);
        wait_int(n);
        check(8'(n > INIT_N - 3 && n < INIT_N + 9), 8'h01);
        rd(ADDR_INT_STATUS, 8'h02);
        rd(ADDR_TX_DISABLE, 8'h00);
        check({tx_en, rx_en}, 8'hff);
        check({tx_sq, rx_sq}, 8'hff);
        conclude();
    end
endmodule
